// >>> adcss_cfg.svh
// Address map, field positions, reset values and timing figures of the sequencer
`ifndef ADCSS_CFG_SVH
`define ADCSS_CFG_SVH
`define ADCSS_OFS_ACTIVE   12'h000
`define ADCSS_OFS_RAW_IRQ  12'h004
`define ADCSS_OFS_IRQ_MASK 12'h008
`define ADCSS_OFS_IRQ_CLR  12'h00c
`define ADCSS_OFS_OVF      12'h010
`define ADCSS_OFS_UNF      12'h018
`define ADCSS_OFS_EVENT    12'h014
`define ADCSS_OFS_PRIO     12'h020
`define ADCSS_OFS_INITIATE 12'h028
`define ADCSS_OFS_AVG      12'h030
`define ADCSS_SEQ_BASE     12'h040
`define ADCSS_SEQ_SPAN     12'hfc0
`define ADCSS_SEQ_MUX      4'h0
`define ADCSS_SEQ_CTL      4'h4
`define ADCSS_SEQ_FIFO     4'h8
`define ADCSS_SEQ_FSTAT    4'hc
`define ADCSS_PRIO_RST     16'h3210
`define ADCSS_EV_PROC      4'h0
`define ADCSS_EV_PIN       4'h4
`define ADCSS_EV_ALWAYS    4'hf
`define ADCSS_STEPS0       4'h8
`define ADCSS_STEPS1       4'h4
`define ADCSS_STEPS2       4'h4
`define ADCSS_STEPS3       4'h1
`define ADCSS_MAX_DEPTH    8
`define ADCSS_CTL_DIFF     0
`define ADCSS_CTL_END      1
`define ADCSS_CTL_IE       2
`define ADCSS_CTL_TEMP     3
`define ADCSS_AVG_MAX      3'h6
`define ADCSS_FST_HEAD     4
`define ADCSS_FST_EMPTY    8
`define ADCSS_FST_FULL     12
`define ADCSS_CLK_KHZ      40000
`define ADCSS_RATE_KSPS    250
`endif

// >>> adcss_pkg.sv
// Types shared by the sequencer and its result queues
`default_nettype none
package adcss_pkg;
  typedef enum logic [1:0] {
    ADCSS_IDLE  = 2'h0,
    ADCSS_ISSUE = 2'h1,
    ADCSS_WAIT  = 2'h3,
    ADCSS_STORE = 2'h2
  } adcss_state_t;
  typedef logic [9:0] adcss_sample_t;
endpackage
`default_nettype wire

// >>> adcss_queue_if.sv
// Push, pop and status bundle between the sequencer and one result queue
`timescale 1ns/1ps
`default_nettype none
interface adcss_queue_if;
  logic                  push;
  adcss_pkg::adcss_sample_t din;
  logic                  pop;
  adcss_pkg::adcss_sample_t dout;
  logic                  full;
  logic                  empty;
  logic [2:0]            head;
  logic [2:0]            tail;
  modport queue (input push, input din, input pop,
                 output dout, output full, output empty, output head, output tail);
  modport ctrl  (output push, output din, output pop,
                 input dout, input full, input empty, input head, input tail);
endinterface
`default_nettype wire

// >>> adcss_result_queue.sv
// Circular result queue of flip-flops, one per sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcss_cfg.svh"
module adcss_result_queue #(
  parameter int unsigned DEPTH = 8
) (
  input wire logic      clock,
  input wire logic      srst,
  adcss_queue_if.queue  q
);
  adcss_pkg::adcss_sample_t mem_r [`ADCSS_MAX_DEPTH];
  logic [2:0]               head_r;
  logic [2:0]               tail_r;
  logic [3:0]               count_r;
  logic                     do_push;
  logic                     do_pop;

  function automatic logic [2:0] wrap_inc(input logic [2:0] p);
    wrap_inc = (p == 3'(DEPTH - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  // Refused operations leave the queue untouched; the caller flags them
  assign do_push = q.push && !q.full;
  assign do_pop  = q.pop && !q.empty;
  assign q.full  = (count_r == 4'(DEPTH));
  assign q.empty = (count_r == 4'h0);
  assign q.head  = head_r;
  assign q.tail  = tail_r;
  assign q.dout  = mem_r[head_r];

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_r[tail_r] <= q.din;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      head_r  <= 3'h0;
      tail_r  <= 3'h0;
      count_r <= 4'h0;
    end else begin
      if (do_push) begin
        tail_r <= wrap_inc(tail_r);
      end
      if (do_pop) begin
        head_r <= wrap_inc(head_r);
      end
      count_r <= count_r + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule
`default_nettype wire

// >>> adcss_top.sv
// Four-sequencer conversion controller with result queues and register port
// Functional notes
// - Each conversion result is a 10-bit unsigned value.
// - Steps may select any of 16 inputs or the internal temperature sensor.
// - Back-to-back requests keep the converter at 250 thousand samples per second.
// - Sequencers hold 8, 4, 4 and 1 steps with equally deep queues.
// - A queue entry reads as 32 bits with the result in bits 9:0.
// - Each step has an input nibble and a control nibble.
// - Control nibble flags: temperature, step interrupt, last step, differential.
// - A sequencer starts only while its active bit is set; configure first.
// - The same input may be chosen by several steps of one sequence.
// - Every step with its interrupt flag raises the sequencer's raw interrupt.
// - The last-step flag ends the sequence; later slots are ignored.
// - Triggered steps run back to back with no software help.
// - Queues are circular; reading the result address pops the oldest entry.
// - Queue status shows head, tail, full and empty per sequencer.
// - Overflow and underflow are recorded per sequencer in two registers.
// - Inputs, trigger, interrupts and priority are set per sequencer.
// - Hardware averaging folds up to 64 conversions into one result.
// - Priorities 0 to 3, 0 highest; concurrent triggers served by priority.
// - Writing one to a clear bit removes that sequencer's pending interrupt.
// - Raw status always visible; masked status forms the interrupt outputs.
`timescale 1ns/1ps
`default_nettype none
`include "adcss_cfg.svh"
module adcss_top (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [3:0]  trig_pin,
  output logic             conv_start,
  output logic      [3:0]  conv_input,
  output logic             conv_diff,
  output logic             conv_temp,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_result,
  output logic      [3:0]  irq_seq
);
  localparam int SAMPLE_CYC = `ADCSS_CLK_KHZ / `ADCSS_RATE_KSPS;

  adcss_pkg::adcss_state_t state_r;
  logic [3:0]  active_r;
  logic [3:0]  raw_r;
  logic [3:0]  mask_r;
  logic [3:0]  ovf_r;
  logic [3:0]  unf_r;
  logic [15:0] event_r;
  logic [15:0] prio_r;
  logic [2:0]  avg_r;
  logic [31:0] mux_r [4];
  logic [31:0] ctl_r [4];
  logic [3:0]  pend_r;
  logic [1:0]  cur_r;
  logic [2:0]  step_r;
  logic [6:0]  avg_cnt_r;
  logic [15:0] acc_r;
  logic [7:0]  gap_r;
  logic [3:0]  trig_s1_r;
  logic [3:0]  trig_s2_r;
  logic [3:0]  trig_s3_r;
  logic [31:0] rd_val;
  logic [3:0]  q_full;
  logic [3:0]  q_empty;
  logic [2:0]  q_head [4];
  logic [2:0]  q_tail [4];
  logic [9:0]  q_dout [4];
  logic [3:0]  q_pop;
  logic [3:0]  trig_now;
  logic [3:0]  ready;
  logic [3:0]  step_ctl;
  logic [3:0]  step_sel;
  logic        last_step;
  logic        store;
  logic        start_seq;
  logic        in_seq;
  logic [1:0]  sn;

  adcss_queue_if q_if [4] ();

  function automatic logic [3:0] seq_steps(input logic [1:0] n);
    case (n)
      2'h0:    seq_steps = `ADCSS_STEPS0;
      2'h1:    seq_steps = `ADCSS_STEPS1;
      2'h2:    seq_steps = `ADCSS_STEPS2;
      default: seq_steps = `ADCSS_STEPS3;
    endcase
  endfunction

  function automatic logic [31:0] step_mask(input logic [1:0] n);
    step_mask = ~(32'hffffffff << {seq_steps(n), 2'h0});
  endfunction

  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Lowest priority value wins; equal values fall back to lower index
  function automatic logic [1:0] best_seq(input logic [3:0] rq, input logic [15:0] pr);
    logic [2:0] bp;
    bp = 3'h4;
    best_seq = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (rq[i] && {1'b0, pr[4*i +: 2]} <= bp) begin
        bp = {1'b0, pr[4*i +: 2]};
        best_seq = 2'(i);
      end
    end
  endfunction

  for (genvar g = 0; g < 4; g++) begin : g_q
    adcss_result_queue #(.DEPTH(int'(seq_steps(2'(g))))) u_q (
      .clock (clock),
      .srst  (srst),
      .q     (q_if[g])
    );
    assign q_if[g].push = store && (cur_r == 2'(g));
    assign q_if[g].din  = 10'(acc_r >> avg_r);
    assign q_if[g].pop  = q_pop[g];
    assign q_full[g]    = q_if[g].full;
    assign q_empty[g]   = q_if[g].empty;
    assign q_head[g]    = q_if[g].head;
    assign q_tail[g]    = q_if[g].tail;
    assign q_dout[g]    = q_if[g].dout;
    assign q_pop[g]     = reg_rd && in_seq && sn == 2'(g)
                          && reg_addr[3:0] == `ADCSS_SEQ_FIFO;
  end

  assign in_seq = (reg_addr & `ADCSS_SEQ_SPAN) == `ADCSS_SEQ_BASE;
  assign sn     = reg_addr[5:4];

  // any nibble value is legal on any step
  assign step_sel  = mux_r[cur_r][{step_r, 2'h0} +: 4];
  assign step_ctl  = ctl_r[cur_r][{step_r, 2'h0} +: 4];
  assign last_step = step_ctl[`ADCSS_CTL_END]
                     || ({1'b0, step_r} == seq_steps(cur_r) - 4'h1);
  assign store     = state_r == adcss_pkg::ADCSS_STORE;
  assign ready     = pend_r & active_r;
  assign start_seq = state_r == adcss_pkg::ADCSS_IDLE && ready != 4'h0;

  // Pin triggers cross in through two flip-flops before edge detection
  always_ff @(posedge clock) begin
    if (srst) begin
      trig_s1_r <= 4'h0;
      trig_s2_r <= 4'h0;
      trig_s3_r <= 4'h0;
    end else begin
      trig_s1_r <= trig_pin;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (event_r[4*i +: 4])
        `ADCSS_EV_PROC:   trig_now[i] = reg_wr && reg_hit(reg_addr, `ADCSS_OFS_INITIATE)
                                        && reg_wdata[i];
        `ADCSS_EV_PIN:    trig_now[i] = trig_s2_r[i] && !trig_s3_r[i];
        `ADCSS_EV_ALWAYS: trig_now[i] = 1'b1;
        default:          trig_now[i] = 1'b0;
      endcase
    end
  end

  // New trigger beats the clear when the sequence is taken
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= (pend_r & ~(start_seq ? 4'(1 << best_seq(ready, prio_r)) : 4'h0))
                | (trig_now & active_r);
    end
  end

  // Software configuration registers
  always_ff @(posedge clock) begin
    if (srst) begin
      active_r <= 4'h0;
      mask_r   <= 4'h0;
      event_r  <= 16'h0000;
      prio_r   <= `ADCSS_PRIO_RST;
      avg_r    <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        mux_r[i] <= 32'h00000000;
        ctl_r[i] <= 32'h00000000;
      end
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, `ADCSS_OFS_ACTIVE)) begin
        active_r <= reg_wdata[3:0];
      end else if (reg_hit(reg_addr, `ADCSS_OFS_IRQ_MASK)) begin
        mask_r <= reg_wdata[3:0];
      end else if (reg_hit(reg_addr, `ADCSS_OFS_EVENT)) begin
        event_r <= reg_wdata[15:0];
      end else if (reg_hit(reg_addr, `ADCSS_OFS_PRIO)) begin
        prio_r <= reg_wdata[15:0] & 16'h3333;
      end else if (reg_hit(reg_addr, `ADCSS_OFS_AVG)) begin
        // 2^n samples, n clamped at 6 (64)
        avg_r <= (reg_wdata[2:0] > `ADCSS_AVG_MAX) ? `ADCSS_AVG_MAX : reg_wdata[2:0];
      end else if (in_seq && reg_addr[3:0] == `ADCSS_SEQ_MUX) begin
        // input nibbles, slots beyond the depth stay zero
        mux_r[sn] <= reg_wdata & step_mask(sn);
      end else if (in_seq && reg_addr[3:0] == `ADCSS_SEQ_CTL) begin
        ctl_r[sn] <= reg_wdata & step_mask(sn);
      end
    end
  end

  // Hardware sets win over software clears in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      raw_r <= 4'h0;
      ovf_r <= 4'h0;
      unf_r <= 4'h0;
    end else begin
      raw_r <= (raw_r & ~(reg_wr && reg_hit(reg_addr, `ADCSS_OFS_IRQ_CLR)
                          ? reg_wdata[3:0] : 4'h0))
               | (store && step_ctl[`ADCSS_CTL_IE] ? 4'(1 << cur_r) : 4'h0);
      // push into full queue flags overflow
      ovf_r <= (ovf_r & ~(reg_wr && reg_hit(reg_addr, `ADCSS_OFS_OVF)
                          ? reg_wdata[3:0] : 4'h0))
               | (store ? 4'(1 << cur_r) & q_full : 4'h0);
      unf_r <= (unf_r & ~(reg_wr && reg_hit(reg_addr, `ADCSS_OFS_UNF)
                          ? reg_wdata[3:0] : 4'h0))
               | (q_pop & q_empty);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_seq <= 4'h0;
    end else begin
      irq_seq <= raw_r & mask_r;
    end
  end

  // request spacing never below one sample period
  always_ff @(posedge clock) begin
    if (srst) begin
      gap_r <= 8'h00;
    end else if (state_r == adcss_pkg::ADCSS_ISSUE && gap_r == 8'h00) begin
      gap_r <= 8'(SAMPLE_CYC - 1);
    end else if (gap_r != 8'h00) begin
      gap_r <= gap_r - 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r    <= adcss_pkg::ADCSS_IDLE;
      cur_r      <= 2'h0;
      step_r     <= 3'h0;
      avg_cnt_r  <= 7'h00;
      acc_r      <= 16'h0000;
      conv_start <= 1'b0;
      conv_input <= 4'h0;
      conv_diff  <= 1'b0;
      conv_temp  <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state_r)
        adcss_pkg::ADCSS_IDLE: begin
          if (start_seq) begin
            cur_r     <= best_seq(ready, prio_r);
            step_r    <= 3'h0;
            avg_cnt_r <= 7'h00;
            acc_r     <= 16'h0000;
            state_r   <= adcss_pkg::ADCSS_ISSUE;
          end
        end
        adcss_pkg::ADCSS_ISSUE: begin
          if (gap_r == 8'h00) begin
            conv_start <= 1'b1;
            conv_input <= step_sel;
            conv_diff  <= step_ctl[`ADCSS_CTL_DIFF];
            conv_temp  <= step_ctl[`ADCSS_CTL_TEMP];
            state_r    <= adcss_pkg::ADCSS_WAIT;
          end
        end
        adcss_pkg::ADCSS_WAIT: begin
          if (conv_done) begin
            acc_r <= acc_r + {6'h00, conv_result};
            if (avg_cnt_r == 7'((1 << avg_r) - 1)) begin
              state_r <= adcss_pkg::ADCSS_STORE;
            end else begin
              avg_cnt_r <= avg_cnt_r + 7'h01;
              state_r   <= adcss_pkg::ADCSS_ISSUE;
            end
          end
        end
        default: begin
          avg_cnt_r <= 7'h00;
          acc_r     <= 16'h0000;
          if (last_step) begin
            state_r <= adcss_pkg::ADCSS_IDLE;
          end else begin
            step_r  <= step_r + 3'h1;
            state_r <= adcss_pkg::ADCSS_ISSUE;
          end
        end
      endcase
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    if (reg_hit(reg_addr, `ADCSS_OFS_ACTIVE)) begin
      rd_val[3:0] = active_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_RAW_IRQ)) begin
      rd_val[3:0] = raw_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_IRQ_MASK)) begin
      rd_val[3:0] = mask_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_IRQ_CLR)) begin
      rd_val[3:0] = raw_r & mask_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_OVF)) begin
      rd_val[3:0] = ovf_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_UNF)) begin
      rd_val[3:0] = unf_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_EVENT)) begin
      rd_val[15:0] = event_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_PRIO)) begin
      rd_val[15:0] = prio_r;
    end else if (reg_hit(reg_addr, `ADCSS_OFS_AVG)) begin
      rd_val[2:0] = avg_r;
    end else if (in_seq && reg_addr[3:0] == `ADCSS_SEQ_MUX) begin
      rd_val = mux_r[sn];
    end else if (in_seq && reg_addr[3:0] == `ADCSS_SEQ_CTL) begin
      rd_val = ctl_r[sn];
    end else if (in_seq && reg_addr[3:0] == `ADCSS_SEQ_FIFO) begin
      // result in low ten bits; empty read gives zero
      rd_val[9:0] = q_empty[sn] ? 10'h000 : q_dout[sn];
    end else if (in_seq && reg_addr[3:0] == `ADCSS_SEQ_FSTAT) begin
      rd_val[2:0] = q_tail[sn];
      rd_val[`ADCSS_FST_HEAD +: 3] = q_head[sn];
      rd_val[`ADCSS_FST_EMPTY]     = q_empty[sn];
      rd_val[`ADCSS_FST_FULL]      = q_full[sn];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// >>> adcss_core_model.sv
// Behavioural converter core that answers each start after a set latency
`timescale 1ns/1ps
`default_nettype none
module adcss_core_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [7:0] lat,
  input  wire logic       conv_start,
  input  wire logic [3:0] conv_input,
  input  wire logic       conv_diff,
  input  wire logic       conv_temp,
  output logic            conv_done,
  output logic      [9:0] conv_result
);
  logic       busy_r;
  logic [7:0] cnt_r;
  logic [9:0] held_r;
  always_ff @(posedge clock) begin
    conv_done <= 1'b0;
    // Released lines toggle so a stale result never looks valid
    conv_result <= ~conv_result;
    if (srst) begin
      busy_r <= 1'b0;
      conv_result <= 10'h155;
    end else if (conv_start) begin
      busy_r <= 1'b1;
      cnt_r <= lat;
      held_r <= {conv_temp, conv_diff, 4'ha, conv_input};
    end else if (busy_r && cnt_r == 8'h0) begin
      busy_r <= 1'b0;
      conv_done <= 1'b1;
      conv_result <= held_r;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h1;
    end
  end
endmodule
`default_nettype wire

// >>> adcss_top_sva.sv
// Port-level assertions for the sequencer top, bound at the foot
`timescale 1ns/1ps
`default_nettype none
`include "adcss_cfg.svh"
module adcss_top_sva (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0]  trig_pin,
  input wire logic        conv_start,
  input wire logic [3:0]  conv_input,
  input wire logic        conv_diff,
  input wire logic        conv_temp,
  input wire logic        conv_done,
  input wire logic [9:0]  conv_result,
  input wire logic [3:0]  irq_seq
);
  logic [7:0]  gap_r;
  logic        busy_r;
  logic [3:0]  msk_r;
  logic        rdv_r;
  logic [11:0] rda_r;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Saturating count of cycles since the last start
  always_ff @(posedge clock) begin
    if (srst || conv_start) begin
      gap_r <= srst ? 8'hff : 8'h0;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h1;
    end
  end
  always_ff @(posedge clock) begin
    busy_r <= !srst && (conv_start || (busy_r && !conv_done));
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      msk_r <= 4'h0;
    end else if (reg_wr && reg_addr == `ADCSS_OFS_IRQ_MASK) begin
      msk_r <= reg_wdata[3:0];
    end
  end
  always_ff @(posedge clock) begin
    rdv_r <= reg_rd && !srst;
    rda_r <= reg_addr;
  end
  chk_start_single: assert property (conv_start |=> !conv_start)
    else $error("conversion start wider than one cycle");
  chk_start_gap: assert property (conv_start |-> gap_r >= 8'h9f)
    else $error("conversion starts closer than the sample period");
  chk_one_open: assert property (conv_start |-> !busy_r)
    else $error("start issued while a conversion is open");
  chk_select_hold: assert property (!conv_start
      |-> $stable({conv_input, conv_diff, conv_temp}))
    else $error("step selects moved without a start");
  chk_read_idle: assert property (!rdv_r |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  chk_result_word: assert property (rdv_r && rda_r[11:6] == 6'h1 && rda_r[3:0] == 4'h8
      |-> reg_rdata[31:10] == 22'h0)
    else $error("result word has bits above the sample");
  chk_status_form: assert property (rdv_r && rda_r[11:6] == 6'h1 && rda_r[3:0] == 4'hc
      |-> (reg_rdata & 32'hffff_ee88) == 32'h0 && !(reg_rdata[8] && reg_rdata[12]))
    else $error("queue status malformed");
  chk_irq_masked: assert property ((irq_seq & ~(msk_r | $past(msk_r))) == 4'h0)
    else $error("interrupt output for a masked sequencer");
endmodule
bind adcss_top adcss_top_sva i_adcss_top_sva (.clock(clock), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trig_pin(trig_pin), .conv_start(conv_start), .conv_input(conv_input),
  .conv_diff(conv_diff), .conv_temp(conv_temp), .conv_done(conv_done),
  .conv_result(conv_result), .irq_seq(irq_seq));
`default_nettype wire

// >>> tb.sv
// Directed bench for the four-sequencer converter controller
`timescale 1ns/1ps
`default_nettype none
`include "adcss_cfg.svh"
module tb;
  logic        clock;
  logic        srst;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [3:0]  trig_pin;
  logic        conv_start;
  logic [3:0]  conv_input;
  logic        conv_diff;
  logic        conv_temp;
  logic        conv_done;
  logic [9:0]  conv_result;
  logic [3:0]  irq_seq;
  logic [7:0]  lat;
  logic [3:0]  ins[$];
  int          num_errors;
  int          checks;
  int          cyc;
  adcss_top i_adcss_top (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_pin(trig_pin), .conv_start(conv_start), .conv_input(conv_input),
    .conv_diff(conv_diff), .conv_temp(conv_temp), .conv_done(conv_done),
    .conv_result(conv_result), .irq_seq(irq_seq));
  adcss_core_model i_adcss_core_model (.clock(clock), .srst(srst), .lat(lat),
    .conv_start(conv_start), .conv_input(conv_input), .conv_diff(conv_diff),
    .conv_temp(conv_temp), .conv_done(conv_done), .conv_result(conv_result));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (!srst && conv_start) ins.push_back(conv_input);
  end
  function automatic logic [11:0] sa(input logic [1:0] n, input logic [3:0] o);
    return `ADCSS_SEQ_BASE + {6'h0, n, o};
  endfunction
  task automatic report_and_stop;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // Waits for n starts in all, then a quiet spell that must bring no more
  task automatic wait_conv(input int n);
    int k;
    k = 0;
    while (ins.size() < n && k < 3000) begin
      @(posedge clock);
      k++;
    end
    repeat (200) @(posedge clock);
    chk(ins.size(), n);
  endtask
  task automatic t_reset;
    rdc(`ADCSS_OFS_PRIO, 32'h3210);
    rdc(`ADCSS_OFS_ACTIVE, 32'h0);
    rdc(sa(0, `ADCSS_SEQ_FSTAT), 32'h100);
    wr(12'h800, 32'hffff_ffff);
    rdc(12'h800, 32'h0);
    wr(sa(3, `ADCSS_SEQ_CTL), 32'hffff_ffff);
    rdc(sa(3, `ADCSS_SEQ_CTL), 32'hf);
  endtask
  task automatic t_seq0;
    logic [31:0] mux;
    logic [31:0] ctl;
    logic [31:0] d;
    int          k;
    // Input 1 and 2 repeat; end flag on the fifth step, later slots live
    mux = 32'h1112_0121;
    ctl = 32'h4446_1840;
    lat = 8'h03;
    wr(sa(0, `ADCSS_SEQ_MUX), mux);
    wr(sa(0, `ADCSS_SEQ_CTL), ctl);
    wr(`ADCSS_OFS_IRQ_MASK, 32'h1);
    wr(`ADCSS_OFS_ACTIVE, 32'h1);
    wr(`ADCSS_OFS_INITIATE, 32'h1);
    wait_conv(5);
    rdc(sa(0, `ADCSS_SEQ_FSTAT), 32'h5);
    rdc(`ADCSS_OFS_RAW_IRQ, 32'h1);
    chk(32'(irq_seq), 32'h1);
    for (k = 0; k < 5; k++) begin
      d = {22'h0, ctl[4*k+3], ctl[4*k], 4'ha, mux[4*k+:4]};
      rdc(sa(0, `ADCSS_SEQ_FIFO), d);
    end
    rdc(sa(0, `ADCSS_SEQ_FSTAT), 32'h155);
    wr(`ADCSS_OFS_IRQ_CLR, 32'h1);
    rdc(`ADCSS_OFS_RAW_IRQ, 32'h0);
    chk(32'(irq_seq), 32'h0);
  endtask
  task automatic t_ovf;
    lat = 8'h64;
    wr(`ADCSS_OFS_AVG, 32'h1);
    wr(sa(3, `ADCSS_SEQ_MUX), 32'h2);
    wr(sa(3, `ADCSS_SEQ_CTL), 32'h2);
    wr(`ADCSS_OFS_ACTIVE, 32'h8);
    wr(`ADCSS_OFS_INITIATE, 32'h8);
    wait_conv(7);
    rdc(sa(3, `ADCSS_SEQ_FSTAT), 32'h1000);
    wr(`ADCSS_OFS_INITIATE, 32'h8);
    wait_conv(9);
    rdc(`ADCSS_OFS_OVF, 32'h8);
    wr(`ADCSS_OFS_OVF, 32'h8);
    rdc(`ADCSS_OFS_OVF, 32'h0);
    rdc(sa(3, `ADCSS_SEQ_FIFO), 32'h0a2);
    rdc(sa(3, `ADCSS_SEQ_FIFO), 32'h0);
    rdc(`ADCSS_OFS_UNF, 32'h8);
    rdc(`ADCSS_OFS_UNF, 32'h8);
    wr(`ADCSS_OFS_UNF, 32'h8);
    rdc(`ADCSS_OFS_UNF, 32'h0);
    wr(`ADCSS_OFS_AVG, 32'h0);
  endtask
  task automatic t_prio;
    lat = 8'h10;
    wr(sa(1, `ADCSS_SEQ_MUX), 32'h1);
    wr(sa(1, `ADCSS_SEQ_CTL), 32'h2);
    wr(sa(2, `ADCSS_SEQ_MUX), 32'h0);
    wr(sa(2, `ADCSS_SEQ_CTL), 32'ha);
    wr(`ADCSS_OFS_PRIO, 32'h3012);
    wr(`ADCSS_OFS_ACTIVE, 32'h0);
    wr(`ADCSS_OFS_INITIATE, 32'h6);
    wait_conv(9);
    wr(`ADCSS_OFS_ACTIVE, 32'h6);
    wr(`ADCSS_OFS_INITIATE, 32'h6);
    wait_conv(11);
    chk(32'(ins[9]), 32'h0);
    chk(32'(ins[10]), 32'h1);
    rdc(sa(2, `ADCSS_SEQ_FIFO), 32'h2a0);
    rdc(sa(1, `ADCSS_SEQ_FIFO), 32'h0a1);
    // Pin edge starts sequencer one; a held level must not restart it
    wr(`ADCSS_OFS_EVENT, 32'h40);
    trig_pin <= 4'h2;
    wait_conv(12);
    trig_pin <= 4'h0;
    rdc(sa(1, `ADCSS_SEQ_FIFO), 32'h0a1);
  endtask
  // Free-running trigger on sequencer three, stopped by its active bit;
  // its step interrupt is set while the mask keeps it off the output
  task automatic t_always;
    int k;
    wr(sa(3, `ADCSS_SEQ_CTL), 32'h6);
    wr(`ADCSS_OFS_EVENT, 32'hf000);
    wr(`ADCSS_OFS_ACTIVE, 32'h8);
    for (k = 0; k < 1000 && ins.size() < 14; k++) @(posedge clock);
    wr(`ADCSS_OFS_ACTIVE, 32'h0);
    wait_conv(14);
    rdc(`ADCSS_OFS_OVF, 32'h8);
    rdc(`ADCSS_OFS_RAW_IRQ, 32'h8);
    rdc(`ADCSS_OFS_IRQ_CLR, 32'h0);
    chk(32'(irq_seq), 32'h0);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 12000) begin
      num_errors++;
      report_and_stop;
    end
  end
  initial begin
    srst = 1'b1;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    trig_pin = 4'h0;
    lat = 8'h03;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_seq0;
    t_ovf;
    t_prio;
    t_always;
    report_and_stop;
  end
endmodule
`default_nettype wire
